// file: tcs_pkg.sv
// ----------------------------------------------------------------
// timer channel status / interrupt register constants
// ----------------------------------------------------------------
package tcs_pkg;

    // bus geometry
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int EVT_W  = 8;                 // sticky event flags

    // register byte addresses
    localparam logic [31:0] OFF_THIRD_CMP   = 32'hf800801c;
    localparam logic [31:0] OFF_STATUS      = 32'hf8008020;
    localparam logic [31:0] OFF_IRQ_SET     = 32'hf8008024;
    localparam logic [31:0] OFF_IRQ_CLR     = 32'hf8008028;
    localparam logic [31:0] OFF_IRQ_MASK    = 32'hf800802c;
    localparam logic [31:0] OFF_WRITE_LOCK  = 32'hf80080e4;
    localparam logic [31:0] OFF_STATUS_CLR  = 32'hf80080f0;

    // event flag positions
    localparam int BIT_OVERFLOW     = 0;
    localparam int BIT_LOAD_OVERRUN = 1;
    localparam int BIT_FIRST_CMP    = 2;
    localparam int BIT_SECOND_CMP   = 3;
    localparam int BIT_THIRD_CMP    = 4;
    localparam int BIT_FIRST_LOAD   = 5;
    localparam int BIT_SECOND_LOAD  = 6;
    localparam int BIT_EXT_TRIGGER  = 7;

    // live status positions
    localparam int BIT_CLOCK_ON     = 16;
    localparam int BIT_LINE_A       = 17;
    localparam int BIT_LINE_B       = 18;

    // write-lock register layout
    localparam int          BIT_LOCK_EN   = 0;
    localparam int          KEY_LSB       = 8;
    localparam logic [23:0] PROTECT_KEY   = 24'h54494d;

    // mode select encoding
    localparam logic WAVE_CAPTURE  = 1'b0;
    localparam logic WAVE_WAVEFORM = 1'b1;

    // flags that may set in each mode
    localparam logic [7:0] ALLOW_CAPTURE  = 8'hf3;
    localparam logic [7:0] ALLOW_WAVEFORM = 8'h9d;

    // reset values
    localparam logic [31:0] RST_THIRD_CMP = 32'h0000_0000;
    localparam logic [7:0]  RST_MASK      = 8'h00;
    localparam logic [7:0]  RST_FLAGS     = 8'h00;
    localparam logic        RST_LOCK      = 1'b0;

endpackage

// file: tcs_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// event carrier between the register front end and the flag bank
// ----------------------------------------------------------------
interface tcs_evt_if;
    logic [7:0] set_v;      // one-cycle event pulses
    logic [7:0] clr_v;      // clear requests
    logic [7:0] allow_v;    // flags legal in the current mode
    logic [7:0] flags_v;    // sticky flags

    modport bank  (input set_v, input clr_v, input allow_v, output flags_v);
    modport owner (output set_v, output clr_v, output allow_v, input flags_v);
endinterface
`default_nettype wire

// file: tcs_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// sticky event flags, set wins over clear
// ----------------------------------------------------------------
module tcs_flag_bank (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // event carrier
    tcs_evt_if.bank  evt
);
    import tcs_pkg::*;

    logic [EVT_W-1:0] flags_ff;     // held flags
    logic [EVT_W-1:0] nxt_flags;    // next flags

    // an event landing on the clear cycle must survive the clear
    assign nxt_flags   = (flags_ff & ~evt.clr_v) | (evt.set_v & evt.allow_v);
    assign evt.flags_v = flags_ff;

    // flag storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_ff <= RST_FLAGS;
        end else begin
            flags_ff <= nxt_flags;
        end
    end
endmodule
`default_nettype wire

// file: tcs_top.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: third compare writable only while unlocked
// R2: third compare reads back its live value
// R3: overflow flag sticky, cleared by status read
// R4: capture mode: double load unread sets overrun
// R5: waveform mode: first compare sets bit 2
// R6: waveform mode: second compare sets bit 3
// R7: third compare match sets bit 4
// R8: capture mode: first capture load sets bit 5
// R9: capture mode: second capture load sets bit 6
// R10: external trigger sets bit 7
// R11: bit 16 shows counter clock live
// R12: bit 17 mirrors line a
// R13: bit 18 mirrors line b
// R14: enable-set writes ones into mask
// R15: enable-clear writes ones out of mask
// R16: mask view returns the eight enables
// R17: mode select zero capture, one waveform
// R18: lock bit changes only with right key
// R19: interrupt while enabled flag set
module tcs_top (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // avalon-mm slave
    input  wire logic [tcs_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [tcs_pkg::DATA_W-1:0] avs_writedata,
    output logic      [tcs_pkg::DATA_W-1:0] avs_readdata,
    output logic                            avs_waitrequest,
    // channel mode and events from the counter logic
    input  wire logic                       wave_mode,
    input  wire logic                       overflow_pulse,
    input  wire logic                       first_cmp_pulse,
    input  wire logic                       second_cmp_pulse,
    input  wire logic                       third_cmp_pulse,
    input  wire logic                       first_load_pulse,
    input  wire logic                       second_load_pulse,
    input  wire logic                       first_read_pulse,
    input  wire logic                       second_read_pulse,
    input  wire logic                       ext_trigger_pulse,
    input  wire logic                       counter_clock_on,
    // io lines: pins and driven levels
    input  wire logic                       io_line_a,
    input  wire logic                       io_line_b,
    input  wire logic                       drive_a,
    input  wire logic                       drive_b,
    // results
    output logic      [tcs_pkg::DATA_W-1:0] third_compare_value,
    output logic                            write_lock_enable,
    output logic                            irq
);
    import tcs_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic              wait_ff;         // high while no answer is offered
    logic [DATA_W-1:0] rdata_ff;        // read answer snapshot
    logic [DATA_W-1:0] rc_ff;           // third compare value
    logic [EVT_W-1:0]  mask_ff;         // interrupt enables
    logic              lock_ff;         // write-lock enable
    logic              irq_ff;          // interrupt output
    logic [1:0]        pin_meta_ff;     // pin synchroniser, stage one
    logic [1:0]        pin_sync_ff;     // pin synchroniser, stage two
    logic [1:0]        pend_ff;         // capture loaded, not yet read

    // next values
    logic              nxt_wait;
    logic [DATA_W-1:0] nxt_rc;
    logic [EVT_W-1:0]  nxt_mask;
    logic              nxt_lock;
    logic              nxt_irq;
    logic [1:0]        nxt_pend;

    tcs_evt_if evt ();                  // carrier to the flag bank

    // ------------------------------------------------------------
    // bus handshake and decode
    // ------------------------------------------------------------
    // every access takes two cycles: the first snapshots read data,
    // the second drops waitrequest; the accept edge is the second
    wire req      = avs_read | avs_write;
    wire load_cyc = req & wait_ff;              // snapshot cycle
    wire acc      = req & ~wait_ff;             // accept cycle
    wire acc_wr   = acc & avs_write;
    wire acc_rd   = acc & avs_read;

    wire sel_rc   = (avs_address == OFF_THIRD_CMP);
    wire sel_sr   = (avs_address == OFF_STATUS);
    wire sel_ier  = (avs_address == OFF_IRQ_SET);
    wire sel_idr  = (avs_address == OFF_IRQ_CLR);
    wire sel_imr  = (avs_address == OFF_IRQ_MASK);
    wire sel_wp   = (avs_address == OFF_WRITE_LOCK);
    wire sel_sc   = (avs_address == OFF_STATUS_CLR);

    assign nxt_wait = ~(req & wait_ff);

    // ------------------------------------------------------------
    // mode and events
    // ------------------------------------------------------------
    // mode decides which flags may set and which read as zero
    wire [EVT_W-1:0] allow = (wave_mode == WAVE_WAVEFORM) ? ALLOW_WAVEFORM
                                                          : ALLOW_CAPTURE; // R17

    // a second load before the first was read is an overrun
    wire ovr_a     = first_load_pulse & pend_ff[0] & ~first_read_pulse;
    wire ovr_b     = second_load_pulse & pend_ff[1] & ~second_read_pulse;
    wire overrun   = ovr_a | ovr_b;                                         // R4

    assign nxt_pend[0] = first_load_pulse | (pend_ff[0] & ~first_read_pulse);
    assign nxt_pend[1] = second_load_pulse | (pend_ff[1] & ~second_read_pulse);

    // event vector into the flag bank
    always_comb begin
        evt.set_v                   = '0;
        evt.set_v[BIT_OVERFLOW]     = overflow_pulse;       // R3
        evt.set_v[BIT_LOAD_OVERRUN] = overrun;              // R4
        evt.set_v[BIT_FIRST_CMP]    = first_cmp_pulse;      // R5
        evt.set_v[BIT_SECOND_CMP]   = second_cmp_pulse;     // R6
        evt.set_v[BIT_THIRD_CMP]    = third_cmp_pulse;      // R7
        evt.set_v[BIT_FIRST_LOAD]   = first_load_pulse;     // R8
        evt.set_v[BIT_SECOND_LOAD]  = second_load_pulse;    // R9
        evt.set_v[BIT_EXT_TRIGGER]  = ext_trigger_pulse;    // R10
    end

    // a status read clears only what the snapshot showed, so an
    // event after the snapshot is kept for the next read
    wire [EVT_W-1:0] rd_clr = (acc_rd & sel_sr) ? rdata_ff[EVT_W-1:0] : '0;   // R3
    wire [EVT_W-1:0] wr_clr = (acc_wr & sel_sc) ? avs_writedata[EVT_W-1:0] : '0;

    // flags of the inactive mode are dropped, so a mode change back
    // does not resurrect stale events
    assign evt.clr_v   = rd_clr | wr_clr | ~allow;
    assign evt.allow_v = allow;

    tcs_flag_bank u_flags (
        .clk (clk),
        .rst (rst),
        .evt (evt)
    );

    wire [EVT_W-1:0] stat_view = evt.flags_v & allow;   // R5 R6 R8 R9

    // ------------------------------------------------------------
    // live status and read mux
    // ------------------------------------------------------------
    // waveform mode shows the driven level, capture mode the pin
    wire mirror_a = wave_mode ? drive_a : pin_sync_ff[0];   // R12
    wire mirror_b = wave_mode ? drive_b : pin_sync_ff[1];   // R13

    logic [DATA_W-1:0] status_word;     // assembled status
    logic [DATA_W-1:0] lock_word;       // write-lock view, key reads 0
    logic [DATA_W-1:0] mask_word;       // mask view

    always_comb begin
        status_word                 = '0;
        status_word[EVT_W-1:0]      = stat_view;
        status_word[BIT_CLOCK_ON]   = counter_clock_on;     // R11
        status_word[BIT_LINE_A]     = mirror_a;             // R12
        status_word[BIT_LINE_B]     = mirror_b;             // R13
        lock_word                   = '0;
        lock_word[BIT_LOCK_EN]      = lock_ff;
        mask_word                   = '0;
        mask_word[EVT_W-1:0]        = mask_ff;              // R16
    end

    // write-only and unmapped addresses read as zero
    wire [DATA_W-1:0] rd_word = sel_rc  ? rc_ff :           // R2
                                sel_sr  ? status_word :
                                sel_imr ? mask_word :
                                sel_wp  ? lock_word : '0;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    wire key_ok = (avs_writedata[DATA_W-1:KEY_LSB] == PROTECT_KEY);

    assign nxt_rc   = (acc_wr & sel_rc & ~lock_ff) ? avs_writedata : rc_ff;        // R1
    assign nxt_lock = (acc_wr & sel_wp & key_ok) ? avs_writedata[BIT_LOCK_EN]
                                                 : lock_ff;                         // R18
    wire [EVT_W-1:0] ier_bits = (acc_wr & sel_ier) ? avs_writedata[EVT_W-1:0] : '0;
    wire [EVT_W-1:0] idr_bits = (acc_wr & sel_idr) ? avs_writedata[EVT_W-1:0] : '0;
    assign nxt_mask = (mask_ff | ier_bits) & ~idr_bits;                             // R14 R15
    assign nxt_irq  = |(stat_view & mask_ff);                                       // R19

    // ------------------------------------------------------------
    // flops
    // ------------------------------------------------------------
    // bus handshake and answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_ff  <= 1'b1;
            rdata_ff <= '0;
        end else begin
            wait_ff <= nxt_wait;
            if (load_cyc & avs_read) begin
                rdata_ff <= rd_word;
            end
        end
    end

    // software-visible registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rc_ff   <= RST_THIRD_CMP;
            mask_ff <= RST_MASK;
            lock_ff <= RST_LOCK;
            irq_ff  <= 1'b0;
        end else begin
            rc_ff   <= nxt_rc;
            mask_ff <= nxt_mask;
            lock_ff <= nxt_lock;
            irq_ff  <= nxt_irq;
        end
    end

    // pin synchroniser and capture pending bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta_ff <= 2'h0;
            pin_sync_ff <= 2'h0;
            pend_ff     <= 2'h0;
        end else begin
            pin_meta_ff <= {io_line_b, io_line_a};
            pin_sync_ff <= pin_meta_ff;
            pend_ff     <= nxt_pend;
        end
    end

    // outputs, all straight from flops
    assign avs_readdata        = rdata_ff;
    assign avs_waitrequest     = wait_ff;
    assign third_compare_value = rc_ff;
    assign write_lock_enable   = lock_ff;
    assign irq                 = irq_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // a read offered: snapshot cycle then the answer cycle
    sequence s_read_of(logic sel);
        load_cyc && avs_read && sel ##1 !avs_waitrequest;
    endsequence

    chk_rc_locked: assert property (acc_wr && sel_rc && lock_ff |=> $stable(rc_ff)) // R1
        else $error("third compare changed while locked");
    chk_rc_written: assert property (
        acc_wr && sel_rc && !lock_ff |=> rc_ff == $past(avs_writedata)) // R1
        else $error("third compare write lost");
    chk_rc_readback: assert property (s_read_of(sel_rc) |-> avs_readdata == rc_ff) // R2
        else $error("third compare read mismatch");
    chk_ovf_sticky: assert property (overflow_pulse |=> evt.flags_v[BIT_OVERFLOW]) // R3
        else $error("overflow flag not set");
    chk_sr_clears: assert property (
        acc_rd && sel_sr && avs_readdata[BIT_OVERFLOW] && !overflow_pulse
        |=> !evt.flags_v[BIT_OVERFLOW]) // R3
        else $error("overflow flag survived status read");
    chk_overrun_set: assert property (
        !wave_mode && first_load_pulse ##1 first_load_pulse && !first_read_pulse
        && !wave_mode |=> stat_view[BIT_LOAD_OVERRUN]) // R4
        else $error("double load did not flag overrun");
    chk_wave_flags: assert property (!wave_mode |-> stat_view[3:2] == 2'h0) // R5 R6
        else $error("compare flag visible in capture mode");
    chk_cmp_set: assert property (wave_mode && first_cmp_pulse ##1 wave_mode
        |-> stat_view[BIT_FIRST_CMP]) // R5
        else $error("first compare flag not set");
    chk_third_cmp: assert property (third_cmp_pulse |=> stat_view[BIT_THIRD_CMP]) // R7
        else $error("third compare flag not set");
    chk_capt_flags: assert property (wave_mode |-> stat_view[6:5] == 2'h0) // R8 R9
        else $error("load flag visible in waveform mode");
    chk_trig_set: assert property (ext_trigger_pulse |=> stat_view[BIT_EXT_TRIGGER]) // R10
        else $error("trigger flag not set");
    chk_live_bits: assert property (s_read_of(sel_sr)
        |-> avs_readdata[BIT_CLOCK_ON] == $past(counter_clock_on)
        && avs_readdata[BIT_LINE_A] == $past(mirror_a)) // R11 R12
        else $error("live status bits wrong");
    chk_mask_set: assert property (acc_wr && sel_ier
        |=> (mask_ff & $past(avs_writedata[7:0])) == $past(avs_writedata[7:0])) // R14
        else $error("enable-set write missed a bit");
    chk_mask_clr: assert property (acc_wr && sel_idr
        |=> (mask_ff & $past(avs_writedata[7:0])) == 8'h00) // R15
        else $error("enable-clear write missed a bit");
    chk_mask_view: assert property (s_read_of(sel_imr)
        |-> avs_readdata == {24'h0, mask_ff}) // R16
        else $error("mask view mismatch");
    chk_bad_key: assert property (acc_wr && sel_wp && !key_ok |=> $stable(lock_ff)) // R18
        else $error("lock changed with wrong key");
    chk_irq_level: assert property (|(stat_view & mask_ff) |=> irq) // R19
        else $error("interrupt missing for enabled flag");
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// testbench: status, mask, lock and third compare over avalon-mm
// ----------------------------------------------------------------
module tb_top;
    import tcs_pkg::*;

    logic        clk, rst;                       // clock and async reset
    logic [31:0] avs_address, avs_writedata;     // bus request
    logic [31:0] avs_readdata, third_compare_value;
    logic        avs_read, avs_write, avs_waitrequest;
    logic        wave_mode, counter_clock_on;    // channel levels
    logic        io_line_a, io_line_b, drive_a, drive_b;
    logic        write_lock_enable, irq;
    logic [8:0]  ev;                             // event pulses, order as ports below
    int          fails, comparisons;

    tcs_top i_dut (
        .clk(clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .wave_mode(wave_mode),
        .overflow_pulse(ev[0]), .first_cmp_pulse(ev[1]), .second_cmp_pulse(ev[2]),
        .third_cmp_pulse(ev[3]), .first_load_pulse(ev[4]), .second_load_pulse(ev[5]),
        .ext_trigger_pulse(ev[6]), .first_read_pulse(ev[7]), .second_read_pulse(ev[8]),
        .counter_clock_on(counter_clock_on), .io_line_a(io_line_a), .io_line_b(io_line_b),
        .drive_a(drive_a), .drive_b(drive_b), .third_compare_value(third_compare_value),
        .write_lock_enable(write_lock_enable), .irq(irq)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    // compare and count; x never matches
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one bus access; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        #1;                                      // let the accept edge land
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    // one-cycle event pulses; flags visible after the second edge
    task automatic evt(input logic [8:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 9'h000;
    endtask

    // expected status word: sticky flags plus live bits
    function automatic logic [31:0] stw(input logic [7:0] f);
        return {13'h0, wave_mode ? drive_b : io_line_b,
                wave_mode ? drive_a : io_line_a, counter_clock_on, 8'h00, f};
    endfunction

    // irq checked once its registered update has landed
    task automatic irq_is(input logic e);
        @(posedge clk);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rdc(OFF_THIRD_CMP, 32'h0);
        rdc(OFF_IRQ_MASK, 32'h0);
        rdc(OFF_STATUS, stw(8'h00));
        chk({31'h0, irq}, 32'h0);
    endtask

    // lock needs the right key both ways; compare frozen while locked
    task automatic t_lock;
        wr(OFF_THIRD_CMP, 32'ha5c30f01);
        rdc(OFF_THIRD_CMP, 32'ha5c30f01);
        chk(third_compare_value, 32'ha5c30f01);
        wr(OFF_WRITE_LOCK, {24'h54494c, 8'h01});
        chk({31'h0, write_lock_enable}, 32'h0);
        wr(OFF_WRITE_LOCK, {PROTECT_KEY, 8'h01});
        chk({31'h0, write_lock_enable}, 32'h1);
        wr(OFF_THIRD_CMP, 32'h12345678);
        rdc(OFF_THIRD_CMP, 32'ha5c30f01);
        wr(OFF_WRITE_LOCK, 32'h0);
        chk({31'h0, write_lock_enable}, 32'h1);
        wr(OFF_WRITE_LOCK, {PROTECT_KEY, 8'h00});
        chk({31'h0, write_lock_enable}, 32'h0);
        wr(OFF_THIRD_CMP, 32'hffffffff);
        rdc(OFF_THIRD_CMP, 32'hffffffff);
        rdc(OFF_WRITE_LOCK, 32'h0);
    endtask

    // write-one set and clear, zeros leave bits alone
    task automatic t_mask;
        wr(OFF_IRQ_SET, 32'hffffff0f);
        rdc(OFF_IRQ_MASK, 32'h0f);
        wr(OFF_IRQ_SET, 32'hf0);
        rdc(OFF_IRQ_MASK, 32'hff);
        wr(OFF_IRQ_CLR, 32'h3c);
        rdc(OFF_IRQ_MASK, 32'hc3);
        wr(OFF_IRQ_CLR, 32'h0);
        rdc(OFF_IRQ_MASK, 32'hc3);
        wr(OFF_IRQ_MASK, 32'h0);
        rdc(OFF_IRQ_MASK, 32'hc3);
        wr(OFF_IRQ_CLR, 32'hff);
        rdc(OFF_IRQ_MASK, 32'h0);
        rdc(32'hf8008030, 32'h0);
    endtask

    // each event alone, then all together, then the read clears
    task automatic t_events(input logic m, input logic [7:0] all, input logic [55:0] tbl);
        @(posedge clk);
        wave_mode <= m;
        drive_a   <= m;
        io_line_b <= !m;
        repeat (4) @(posedge clk);
        evt(9'h180);                             // drop loads left pending by earlier runs
        for (int i = 0; i < 7; i++) begin
            evt(9'h001 << i);
            rdc(OFF_STATUS, stw(tbl[8*i +: 8]));
        end
        evt(9'h07f);
        rdc(OFF_STATUS, stw(all));
        rdc(OFF_STATUS, stw(8'h00));
    endtask

    // overrun needs a second load with no read between
    task automatic t_overrun;
        evt(9'h180);
        evt(9'h030);
        rdc(OFF_STATUS, stw(8'h60));
        evt(9'h010);
        rdc(OFF_STATUS, stw(8'h22));
        // two loads on back-to-back cycles
        @(posedge clk);
        ev <= 9'h010;
        repeat (2) @(posedge clk);
        ev <= 9'h000;
        rdc(OFF_STATUS, stw(8'h22));
    endtask

    // live bits follow their sources and survive reads
    task automatic t_live;
        evt(9'h002);
        @(posedge clk);
        wave_mode        <= WAVE_CAPTURE;
        counter_clock_on <= 1'b1;
        io_line_a        <= 1'b1;
        io_line_b        <= 1'b0;
        repeat (4) @(posedge clk);
        rdc(OFF_STATUS, stw(8'h00));
        rdc(OFF_STATUS, 32'h00030000);
        @(posedge clk);
        wave_mode        <= WAVE_WAVEFORM;
        drive_a          <= 1'b0;
        drive_b          <= 1'b1;
        counter_clock_on <= 1'b0;
        repeat (2) @(posedge clk);
        rdc(OFF_STATUS, 32'h00040000);
    endtask

    // interrupt follows flag and mask together
    task automatic t_irq;
        wr(OFF_IRQ_SET, 32'h80);
        evt(9'h001);
        irq_is(1'b0);
        evt(9'h040);
        irq_is(1'b1);
        wr(OFF_IRQ_CLR, 32'h80);
        irq_is(1'b0);
        wr(OFF_IRQ_SET, 32'h80);
        irq_is(1'b1);
        rdc(OFF_STATUS, stw(8'h81));
        irq_is(1'b0);
    endtask

    // ----------------------------------------------------------------
    // verdict, clock, watchdog, main sequence
    // ----------------------------------------------------------------
    task automatic tally_and_finish;
        if (fails == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // whole run is a few hundred cycles
    initial begin
        #300000;
        fails++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1; avs_address = 32'h0; avs_writedata = 32'h0;
        avs_read = 1'b0; avs_write = 1'b0; ev = 9'h000;
        wave_mode = 1'b0; counter_clock_on = 1'b0;
        io_line_a = 1'b0; io_line_b = 1'b0; drive_a = 1'b0; drive_b = 1'b0;
        fails = 0; comparisons = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_lock();
        t_mask();
        t_events(WAVE_WAVEFORM, 8'h9d, 56'h80_00_00_10_08_04_01);
        t_events(WAVE_CAPTURE, 8'hf3, 56'h80_40_20_10_00_00_01);
        t_overrun();
        t_live();
        t_irq();
        tally_and_finish();
    end
endmodule
`default_nettype wire
